/* File: shared/ulms_pkg.sv */
// Constants, register layout and cycle states for the upper/lower memory select block
`default_nettype none
package ulms_pkg;
    // ******************************************************
    // Register offsets
    // ******************************************************
    localparam logic [7:0]  REG_UPPER_OFS  = 8'ha0;
    localparam logic [7:0]  REG_LOWER_OFS  = 8'ha2;
    localparam logic [7:0]  REG_STATUS_OFS = 8'hae;
    // ******************************************************
    // Field positions and widths
    // ******************************************************
    localparam int          BOUND_LSB      = 12;
    localparam int          BOUND_W        = 3;
    localparam int          DA_BIT         = 7;
    localparam int          PSE_BIT        = 6;
    localparam int          READY_BIT      = 2;
    localparam int          WS_LSB         = 0;
    localparam int          WS_W           = 2;
    localparam int          ST_LOWER_ACT   = 0;
    localparam int          ST_ADEN        = 1;
    localparam int          ST_BUSY        = 2;
    localparam int          ST_PSRAM       = 3;
    // ******************************************************
    // Reset values
    // ******************************************************
    localparam logic [15:0] UPPER_RESET    = 16'hf03b;
    localparam logic [2:0]  REGION_MSB_UP  = 3'h7;
    // ******************************************************
    // Bus cycle states
    // ******************************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_T1   = 6'b000010,
        ST_T2   = 6'b000100,
        ST_T3   = 6'b001000,
        ST_TW   = 6'b010000,
        ST_T4   = 6'b100000
    } ulms_state_t;
endpackage : ulms_pkg
`default_nettype wire

/* File: rtl/ulms_wait.sv */
// Wait-state counter and external ready qualifier for one bus cycle
`default_nettype none
module ulms_wait (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Cycle control
    input  wire logic       load,
    input  wire logic       active,
    input  wire logic [1:0] ws,
    input  wire logic       need_ready,
    input  wire logic       ready,
    // Result
    output logic            go
);
    // ******************************************************
    // Counter and ready latch
    // ******************************************************
    logic [1:0] cnt;
    logic       rdy_seen;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= 2'h0;
        end else if (load) begin
            cnt <= ws;
        end else if (active && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end
    end

    // Ready seen early is remembered so a short pulse is not lost
    always_ff @(posedge clk) begin
        if (reset || load) begin
            rdy_seen <= 1'b0;
        end else if (active && ready) begin
            rdy_seen <= 1'b1;
        end
    end

    // Internal waits always finish first, ready only extends
    assign go = active && (cnt == 2'h0) && (!need_ready || rdy_seen || ready);
endmodule : ulms_wait
`default_nettype wire

/* File: rtl/ulms_top.sv */
// Upper/lower memory select: region decode, wait states and address-phase bus control
//
// The strobed register port is this design's own decision.
`default_nettype none
module ulms_top #(
    parameter bit BYTE_BUS = 1'b0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Bus cycle request from the core
    input  wire logic        cyc_start,
    input  wire logic [19:0] cyc_addr,
    input  wire logic        cyc_mem,
    output logic             cyc_busy,
    output logic             cyc_done,
    // Pins
    input  wire logic        high_byte_addr_enable_strap,
    input  wire logic        async_ready_in,
    input  wire logic        sync_ready_in,
    output logic             upper_mem_select_n,
    output logic             lower_mem_select_n,
    output logic             nonmux_addr_oe,
    output logic      [19:0] nonmux_addr_bus,
    output logic             muxed_addr_oe,
    output logic             upper_addr_oe,
    output logic             psram_cycle
);
    // ******************************************************
    // Decode helpers
    // ******************************************************
    // Masked compare of address bits 18:16 (the three below bit 19) against a bound
    function automatic logic bound_match(input logic [2:0] a, input logic [2:0] bound, input logic upper);
        if (upper) begin
            bound_match = (a & bound) == bound;
        end else begin
            bound_match = (a & ~bound) == 3'h0;
        end
    endfunction : bound_match

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // ******************************************************
    // Pin synchronisers
    // ******************************************************
    logic [1:0] strap_sync;
    logic [1:0] async_ready_in_sync;
    logic [1:0] sync_ready_in_sync;
    logic       ready_any;

    always_ff @(posedge clk) begin
        strap_sync <= {strap_sync[0], high_byte_addr_enable_strap};
        async_ready_in_sync  <= {async_ready_in_sync[0], async_ready_in};
        sync_ready_in_sync  <= {sync_ready_in_sync[0], sync_ready_in};
    end

    assign ready_any = async_ready_in_sync[1] | sync_ready_in_sync[1];

    // ******************************************************
    // Strap capture at reset release
    // ******************************************************
    logic reset_q;
    logic aden;

    always_ff @(posedge clk) begin
        reset_q <= reset;
    end

    // Caught in the first cycle after release, not under reset
    always_ff @(posedge clk) begin
        if (reset) begin
            aden <= 1'b0;
        end else if (reset_q) begin
            aden <= strap_sync[1];
        end
    end

    // ******************************************************
    // Configuration registers
    // ******************************************************
    logic [15:0] upper_region_config;
    logic [15:0] lower_region_config;
    logic        lower_active;
    logic        wr_upper;
    logic        wr_lower;
    logic        acc_lower;

    assign wr_upper  = reg_wr && reg_hit(reg_addr, ulms_pkg::REG_UPPER_OFS);
    assign wr_lower  = reg_wr && reg_hit(reg_addr, ulms_pkg::REG_LOWER_OFS);
    assign acc_lower = (reg_wr || reg_rd) && reg_hit(reg_addr, ulms_pkg::REG_LOWER_OFS);

    // Reserved bits are stored as written; software fills them
    always_ff @(posedge clk) begin
        if (reset) begin
            upper_region_config <= ulms_pkg::UPPER_RESET;
        end else if (wr_upper) begin
            upper_region_config <= reg_wdata;
        end
    end

    // No reset: contents only matter once the region is enabled
    always_ff @(posedge clk) begin
        if (wr_lower) begin
            lower_region_config <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lower_active <= 1'b0;
        end else if (acc_lower) begin
            lower_active <= 1'b1;
        end
    end

    // ******************************************************
    // Register read port
    // ******************************************************
    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[ulms_pkg::ST_LOWER_ACT] = lower_active;
        status_word[ulms_pkg::ST_ADEN]      = aden;
        status_word[ulms_pkg::ST_BUSY]      = cyc_busy;
        status_word[ulms_pkg::ST_PSRAM]     = psram_cycle;
    end

    // Unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_hit(reg_addr, ulms_pkg::REG_UPPER_OFS)) begin
                reg_rdata <= upper_region_config;
            end else if (reg_hit(reg_addr, ulms_pkg::REG_LOWER_OFS)) begin
                reg_rdata <= lower_region_config;
            end else if (reg_hit(reg_addr, ulms_pkg::REG_STATUS_OFS)) begin
                reg_rdata <= status_word;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ******************************************************
    // Region decode
    // ******************************************************
    logic [2:0] lower_bound_field;
    logic [2:0] upper_bound_field;
    logic       hit_upper;
    logic       hit_lower;

    assign lower_bound_field = upper_region_config[ulms_pkg::BOUND_LSB +: ulms_pkg::BOUND_W];
    assign upper_bound_field = lower_region_config[ulms_pkg::BOUND_LSB +: ulms_pkg::BOUND_W];

    // Upper always runs to FFFFFh; lower always starts at 00000h
    assign hit_upper = cyc_mem && cyc_addr[19]
                     && bound_match(cyc_addr[18:16], lower_bound_field, 1'b1);
    assign hit_lower = cyc_mem && lower_active && !cyc_addr[19]
                     && bound_match(cyc_addr[18:16], upper_bound_field, 1'b0);

    // ******************************************************
    // Per-cycle settings latched at the start
    // ******************************************************
    logic       sel_upper;
    logic       sel_lower;
    logic       cyc_need_ready;
    logic [1:0] cyc_ws;
    logic       next_da;
    logic       next_need_ready;
    logic [1:0] next_ws;

    always_comb begin
        next_da         = 1'b0;
        next_need_ready = 1'b0;
        next_ws         = 2'h0;
        if (hit_upper) begin
            next_da         = upper_region_config[ulms_pkg::DA_BIT];
            next_need_ready = !upper_region_config[ulms_pkg::READY_BIT];
            next_ws         = upper_region_config[ulms_pkg::WS_LSB +: ulms_pkg::WS_W];
        end else if (hit_lower) begin
            next_da         = lower_region_config[ulms_pkg::DA_BIT];
            next_need_ready = !lower_region_config[ulms_pkg::READY_BIT];
            next_ws         = lower_region_config[ulms_pkg::WS_LSB +: ulms_pkg::WS_W];
        end
    end

    ulms_pkg::ulms_state_t state;
    logic                  wait_go;

    always_ff @(posedge clk) begin
        if (reset) begin
            sel_upper      <= 1'b0;
            sel_lower      <= 1'b0;
            cyc_need_ready <= 1'b0;
            cyc_ws         <= 2'h0;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            sel_upper      <= hit_upper;
            sel_lower      <= hit_lower && !hit_upper;
            cyc_need_ready <= next_need_ready;
            cyc_ws         <= next_ws;
        end else if (state == ulms_pkg::ST_T4) begin
            sel_upper <= 1'b0;
            sel_lower <= 1'b0;
        end
    end

    // ******************************************************
    // Bus cycle sequencer
    // ******************************************************
    ulms_pkg::ulms_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            ulms_pkg::ST_IDLE: begin
                if (cyc_start) begin
                    next_state = ulms_pkg::ST_T1;
                end
            end
            ulms_pkg::ST_T1: next_state = ulms_pkg::ST_T2;
            ulms_pkg::ST_T2: next_state = ulms_pkg::ST_T3;
            ulms_pkg::ST_T3, ulms_pkg::ST_TW: begin
                next_state = wait_go ? ulms_pkg::ST_T4 : ulms_pkg::ST_TW;
            end
            ulms_pkg::ST_T4: next_state = ulms_pkg::ST_IDLE;
            default: next_state = ulms_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ulms_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycles outside both regions still wait on ready, no waits
    ulms_wait u_wait (
        .clk        (clk),
        .reset      (reset),
        .load       (state == ulms_pkg::ST_T2),
        .active     (state == ulms_pkg::ST_T3 || state == ulms_pkg::ST_TW),
        .ws         (cyc_ws),
        .need_ready (cyc_need_ready || !(sel_upper || sel_lower)),
        .ready      (ready_any),
        .go         (wait_go)
    );

    // ******************************************************
    // Pin outputs
    // ******************************************************
    logic in_cycle;

    assign in_cycle = (state != ulms_pkg::ST_IDLE);

    // Selects and the demultiplexed address move together from T1
    always_ff @(posedge clk) begin
        if (reset) begin
            nonmux_addr_bus <= 20'h00000;
            nonmux_addr_oe  <= 1'b0;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            nonmux_addr_bus <= cyc_addr;
            nonmux_addr_oe  <= 1'b1;
        end else if (state == ulms_pkg::ST_T4) begin
            nonmux_addr_oe  <= 1'b0;
        end
    end

    // Selects straight from flops: decoded state bits could glitch a pin
    always_ff @(posedge clk) begin
        if (reset) begin
            upper_mem_select_n <= 1'b1;
            lower_mem_select_n <= 1'b1;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            upper_mem_select_n <= !hit_upper;
            lower_mem_select_n <= !(hit_lower && !hit_upper);
        end else if (state == ulms_pkg::ST_T4) begin
            upper_mem_select_n <= 1'b1;
            lower_mem_select_n <= 1'b1;
        end
    end

    // Address phase is T1; suppression only with the strap high
    always_ff @(posedge clk) begin
        if (reset) begin
            muxed_addr_oe <= 1'b0;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            muxed_addr_oe <= !(next_da && aden);
        end else begin
            muxed_addr_oe <= 1'b0;
        end
    end

    // Byte variant keeps the upper address lines through the data phase
    always_ff @(posedge clk) begin
        if (reset) begin
            upper_addr_oe <= 1'b0;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            upper_addr_oe <= BYTE_BUS;
        end else if (state == ulms_pkg::ST_T4) begin
            upper_addr_oe <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            psram_cycle <= 1'b0;
        end else if (state == ulms_pkg::ST_IDLE && cyc_start) begin
            psram_cycle <= hit_lower && !hit_upper && lower_region_config[ulms_pkg::PSE_BIT];
        end else if (state == ulms_pkg::ST_T4) begin
            psram_cycle <= 1'b0;
        end
    end
    assign cyc_busy    = in_cycle;
    assign cyc_done    = (state == ulms_pkg::ST_T4);
endmodule : ulms_top
`default_nettype wire

/* File: testbench/ulms_mem_model.sv */
// External memory model: answers bus cycles on either ready pin after a lag
`default_nettype none
module ulms_mem_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bus activity and behaviour
    input  wire logic       bus_act,
    input  wire logic [3:0] lag,
    input  wire logic       use_sync,
    // Ready pins
    output logic            async_ready_in,
    output logic            sync_ready_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    logic       rdy;
    always_ff @(posedge clk) begin
        if (reset || !bus_act) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
    end
    // Low outside cycles, so a stale ready never ends the next one
    assign rdy = bus_act && (cnt >= lag);
    assign async_ready_in = rdy && !use_sync;
    assign sync_ready_in = rdy && use_sync;
endmodule : ulms_mem_model
`default_nettype wire

/* File: testbench/ulms_top_properties.sv */
// Port checks for the memory select block
`default_nettype none
module ulms_top_properties #(
    parameter bit BYTE_BUS = 1'b0
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        cyc_start,
    input wire logic        cyc_mem,
    input wire logic        cyc_busy,
    input wire logic        cyc_done,
    input wire logic        upper_mem_select_n,
    input wire logic        lower_mem_select_n,
    input wire logic        nonmux_addr_oe,
    input wire logic [19:0] nonmux_addr_bus,
    input wire logic        muxed_addr_oe,
    input wire logic        upper_addr_oe,
    input wire logic        psram_cycle
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        cyc_start && !cyc_busy;
    endsequence
    sequence s_no_done;
        !cyc_done [*3];
    endsequence
    property p_io_no_sel;
        s_take ##0 !cyc_mem |=> (upper_mem_select_n && lower_mem_select_n) [*4];
    endproperty
    a_io_no_sel: assert property (p_io_no_sel) else $error("select in io cycle");
    property p_min_len;
        s_take |=> s_no_done;
    endproperty
    a_min_len: assert property (p_min_len) else $error("cycle too short");
    property p_done_idle;
        cyc_done |=> !cyc_busy;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("busy after done");
    property p_sel_addr;
        $fell(upper_mem_select_n) || $fell(lower_mem_select_n) |-> $rose(nonmux_addr_oe);
    endproperty
    a_sel_addr: assert property (p_sel_addr) else $error("select not with address");
    property p_up_top;
        !upper_mem_select_n |-> nonmux_addr_bus[19] && nonmux_addr_oe;
    endproperty
    a_up_top: assert property (p_up_top) else $error("upper select below 80000");
    property p_low_base;
        !lower_mem_select_n |-> !nonmux_addr_bus[19] && nonmux_addr_oe;
    endproperty
    a_low_base: assert property (p_low_base) else $error("lower select above 7ffff");
    property p_one_sel;
        !(!upper_mem_select_n && !lower_mem_select_n);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("both selects low");
    property p_mux_t1;
        muxed_addr_oe |-> $rose(nonmux_addr_oe);
    endproperty
    a_mux_t1: assert property (p_mux_t1) else $error("muxed bus outside address phase");
    property p_byte;
        nonmux_addr_oe |-> upper_addr_oe == BYTE_BUS;
    endproperty
    a_byte: assert property (p_byte) else $error("upper address outputs wrong");
    property p_psram;
        psram_cycle |-> !lower_mem_select_n;
    endproperty
    a_psram: assert property (p_psram) else $error("psram outside lower region");
endmodule : ulms_top_properties
bind ulms_top ulms_top_properties #(.BYTE_BUS(BYTE_BUS)) u_props (.clk(clk), .reset(reset),
    .cyc_start(cyc_start), .cyc_mem(cyc_mem), .cyc_busy(cyc_busy), .cyc_done(cyc_done),
    .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
    .nonmux_addr_oe(nonmux_addr_oe), .nonmux_addr_bus(nonmux_addr_bus), .muxed_addr_oe(muxed_addr_oe),
    .upper_addr_oe(upper_addr_oe), .psram_cycle(psram_cycle));
`default_nettype wire

/* File: testbench/tb_upper_lower_memory_select.sv */
// Testbench for the memory select block
`default_nettype none
module tb_upper_lower_memory_select;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset, reg_wr, reg_rd, cyc_start, cyc_mem, cyc_busy, cyc_done, high_byte_addr_enable_strap;
    logic async_ready_in, sync_ready_in, upper_mem_select_n, lower_mem_select_n, nonmux_addr_oe;
    logic muxed_addr_oe, upper_addr_oe, psram_cycle, use_sync;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [19:0] cyc_addr, nonmux_addr_bus, d, n, s_u, s_l, s_m, s_o, s_p, s_a;
    logic [3:0] lag;
    int fail_count = 0;
    int n_tests = 0;
    logic [2:0] ub [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [19:0] le [4] = '{20'h0ffff, 20'h1ffff, 20'h3ffff, 20'h7ffff};
    logic [2:0] lb [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    logic [19:0] us [4] = '{20'hf0000, 20'he0000, 20'hc0000, 20'h80000};
    ulms_top #(.BYTE_BUS(1'b1)) u_ulms_top (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cyc_start, .cyc_addr, .cyc_mem, .cyc_busy, .cyc_done, .high_byte_addr_enable_strap,
        .async_ready_in, .sync_ready_in, .upper_mem_select_n, .lower_mem_select_n, .nonmux_addr_oe,
        .nonmux_addr_bus, .muxed_addr_oe, .upper_addr_oe, .psram_cycle);
    ulms_mem_model u_ulms_mem_model (.clk, .reset, .bus_act(nonmux_addr_oe), .lag, .use_sync,
        .async_ready_in, .sync_ready_in);
    always #25 clk = ~clk;
    task automatic chk(input logic [19:0] g, input logic [19:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = {4'h0, reg_rdata};
    endtask : rd
    // Samples the address phase, then counts cycles up to the done pulse
    task cyc(input logic [19:0] a, input logic m);
        @(posedge clk);
        cyc_start <= 1'b1;
        cyc_addr <= a;
        cyc_mem <= m;
        @(posedge clk);
        cyc_start <= 1'b0;
        #1 s_u = 20'(upper_mem_select_n);
        s_l = 20'(lower_mem_select_n);
        s_m = 20'(muxed_addr_oe);
        s_o = 20'(upper_addr_oe);
        s_p = 20'(psram_cycle);
        s_a = nonmux_addr_bus;
        n = 20'h1;
        while (cyc_done !== 1'b1 && n < 20'h3c) begin
            @(posedge clk);
            #1 n = n + 20'h1;
        end
        @(posedge clk);
    endtask : cyc
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task do_reset(input logic s);
        reset <= 1'b1;
        high_byte_addr_enable_strap <= s;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    // Generous bound; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        {reset, reg_wr, reg_rd, cyc_start, cyc_mem, use_sync} = '0;
        {reg_addr, reg_wdata, cyc_addr, lag} = '0;
        do_reset(1'b1);
        rd(8'ha0); chk(d, 20'hf03b, "upper reset value");
        rd(8'hae); chk(d, 20'(1 << ulms_pkg::ST_ADEN), "strap high captured");
        cyc(20'hffff0, 1'b1); chk(s_u, 20'h0, "upper at reset");
        chk(n, 20'h7, "reset cycle length");
        chk(s_a, 20'hffff0, "address with select");
        chk(s_m, 20'h1, "disable bit clear");
        cyc(20'hefff0, 1'b1); chk(s_u, 20'h1, "below upper window");
        cyc(20'h00100, 1'b1); chk(s_l, 20'h1, "lower idle");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'ha2, {1'b0, ub[i], 12'hf3c});
            cyc(le[i], 1'b1); chk(s_l, 20'h0, "lower end inside");
            cyc(le[i] + 20'h1, 1'b1); chk(s_l, 20'h1, "lower end outside");
        end
        cyc(20'h00000, 1'b1); chk(s_l, 20'h0, "lower base");
        $display("test lower done");
        for (int i = 0; i < 4; i++) begin
            wr(8'ha0, {1'b1, lb[i], 12'h03c});
            rd(8'ha0); chk(d, {5'h1, lb[i], 12'h03c}, "upper readback");
            cyc(us[i], 1'b1); chk(s_u, 20'h0, "upper start inside");
            cyc(us[i] - 20'h1, 1'b1); chk(s_u, 20'h1, "upper start outside");
        end
        $display("test upper done");
        lag <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            wr(8'ha0, {14'h3c0f, i[1:0]});
            cyc(20'hf0000, 1'b1); chk(n, 20'(4 + i), "waits, ready ignored");
        end
        lag <= 4'hc;
        wr(8'ha0, 16'hf039);
        cyc(20'hf0000, 1'b1); chk(20'(n > 20'h6 && n < 20'h19), 20'h1, "ready extends");
        wr(8'ha0, 16'hf038);
        for (int i = 0; i < 2; i++) begin
            lag <= 4'h3;
            use_sync <= i[0];
            cyc(20'hf0000, 1'b1); chk(20'(n > 20'h4 && n < 20'h14), 20'h1, "either ready pin");
        end
        $display("test ready done");
        wr(8'ha0, 16'hf0bc);
        cyc(20'hf0000, 1'b1); chk(s_m, 20'h0, "upper bus floated");
        chk(s_o, 20'h1, "upper address kept");
        chk(s_p, 20'h0, "no psram in upper");
        wr(8'ha2, 16'h7f7c);
        cyc(20'h00100, 1'b1); chk(s_m, 20'h1, "lower bus driven");
        chk(s_p, 20'h1, "psram on");
        wr(8'ha2, 16'h7fbc);
        cyc(20'h00100, 1'b1); chk(s_m, 20'h0, "lower bus floated");
        chk(s_p, 20'h0, "psram off");
        cyc(20'hf0000, 1'b0); chk(s_u & s_l, 20'h1, "io cycle");
        $display("test bus done");
        do_reset(1'b0);
        rd(8'ha0); chk(d, 20'hf03b, "upper reset again");
        cyc(20'h00100, 1'b1); chk(s_l, 20'h1, "lower idle again");
        rd(8'ha2);
        cyc(20'h00100, 1'b1); chk(s_l, 20'h0, "read enables lower");
        chk(s_m, 20'h1, "strap low drives");
        rd(8'hae); chk(d, 20'(1 << ulms_pkg::ST_LOWER_ACT), "strap low captured");
        $display("test strap done");
        wrap_up();
    end
endmodule : tb_upper_lower_memory_select
`default_nettype wire
